// ---- rtl/msp_dev.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Write-byte buffer
// ------------------------------------------------------------
module msp_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 16
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_reg [DEPTH];
   logic [AW:0]  wp_reg;
   logic [AW:0]  rp_reg;
   logic         push;
   logic         pop;

   assign in_ready  = !(wp_reg[AW] != rp_reg[AW] && wp_reg[AW-1:0] == rp_reg[AW-1:0]);
   assign out_valid = wp_reg != rp_reg;
   assign out_data  = mem_reg[rp_reg[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (srst) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else begin
         if (push) wp_reg <= wp_reg + 1'b1;
         if (pop) rp_reg <= rp_reg + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (push) mem_reg[wp_reg[AW-1:0]] <= in_data;
   end
endmodule // msp_fifo

// ------------------------------------------------------------
// Device end of the serial port
// ------------------------------------------------------------
module msp_dev #(
   parameter int DEPTH = msp_pkg::FIFO_DEPTH
) (
   input  wire logic        clk,
   input  wire logic        srst,
   msp_if.dev               link,
   output logic             wr_valid,
   input  wire logic        wr_ready,
   output logic [5:0]       wr_addr,
   output logic [1:0]       wr_lane,
   output logic [7:0]       wr_byte,
   output logic             wr_drop,
   input  wire logic        upd_valid,
   input  wire logic [5:0]  upd_addr,
   input  wire logic [23:0] upd_data,
   output logic [5:0]       ones_count
);
   logic [2:0]                  sync1_reg;
   logic [2:0]                  sync2_reg;
   logic                        sclk_prev_reg;
   logic                        cs_prev_reg;
   msp_pkg::msp_dev_st_t        st_reg;
   logic [4:0]                  cnt_reg;
   logic [7:0]                  cmd_sh_reg;
   logic [7:0]                  rx_sh_reg;
   logic [5:0]                  addr_reg;
   logic [1:0]                  nb_reg;
   logic [23:0]                 tx_reg;
   logic                        dout_reg;
   logic                        oe_reg;
   logic [5:0]                  chk_reg;
   logic                        drop_reg;
   logic                        push_reg;
   logic [15:0]                 push_data_reg;
   logic [23:0]                 regs_reg [64];
   logic                        fifo_ready;
   logic [15:0]                 fifo_out;

   logic       sclk_s, cs_s, din_s, fall, rise, cs_edge, act, decode;
   logic [7:0] cmd_next;
   logic [7:0] rx_next;
   logic [5:0] dec_addr;
   logic [1:0] dec_nb;
   logic [23:0] rd_val;

   // ------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ------------------------------------------------------------
   // Reset to the idle pin levels so no false clock edge follows reset
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_reg     <= 3'h6;
         sync2_reg     <= 3'h6;
         sclk_prev_reg <= 1'b1;
         cs_prev_reg   <= 1'b1;
      end else begin
         sync1_reg     <= {link.sclk, link.cs_n, link.din};
         sync2_reg     <= sync1_reg;
         sclk_prev_reg <= sync2_reg[2];
         cs_prev_reg   <= sync2_reg[1];
      end
   end

   assign sclk_s   = sync2_reg[2];
   assign cs_s     = sync2_reg[1];
   assign din_s    = sync2_reg[0];
   assign fall     = sclk_prev_reg && !sclk_s;
   assign rise     = !sclk_prev_reg && sclk_s;
   assign cs_edge  = cs_prev_reg != cs_s;
   assign act      = !cs_s && !cs_edge;
   assign cmd_next = {cmd_sh_reg[6:0], din_s};
   assign rx_next  = {rx_sh_reg[6:0], din_s};
   assign decode   = act && fall && st_reg == msp_pkg::MSP_CMD && cnt_reg == 5'h07;
   assign dec_addr = cmd_next[5:0];
   assign dec_nb   = msp_pkg::msp_reg_bytes(dec_addr);
   // Checksum register reads its pre-clear value
   assign rd_val   = (dec_addr == msp_pkg::CHK_ADDR) ? {18'h00000, chk_reg}
                                                     : regs_reg[dec_addr];

   // ------------------------------------------------------------
   // Transfer sequencing
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst || cs_edge) begin
         st_reg     <= msp_pkg::MSP_CMD;
         cnt_reg    <= 5'h00;
         cmd_sh_reg <= 8'h00;
      end else if (act) begin
         case (st_reg)
            msp_pkg::MSP_CMD: begin
               if (fall) begin
                  cmd_sh_reg <= cmd_next;
                  cnt_reg    <= 5'(cnt_reg + 5'h01);
                  if (decode) begin
                     cnt_reg  <= 5'h00;
                     addr_reg <= dec_addr;
                     nb_reg   <= dec_nb;
                     st_reg   <= cmd_next[msp_pkg::CMD_RW_POS] ? msp_pkg::MSP_WR
                                                              : msp_pkg::MSP_RD;
                  end
               end
            end
            msp_pkg::MSP_WR: begin
               if (fall) begin
                  rx_sh_reg <= rx_next;
                  cnt_reg   <= 5'(cnt_reg + 5'h01);
                  if (cnt_reg[2:0] == 3'h7 && cnt_reg[4:3] == nb_reg - 2'h1) begin
                     st_reg  <= msp_pkg::MSP_CMD;
                     cnt_reg <= 5'h00;
                  end
               end
            end
            msp_pkg::MSP_RD: begin
               if (rise) cnt_reg <= 5'(cnt_reg + 5'h01);
               if (fall && cnt_reg == {nb_reg, 3'h0}) begin
                  st_reg  <= msp_pkg::MSP_CMD;
                  cnt_reg <= 5'h00;
               end
            end
            default: st_reg <= msp_pkg::MSP_CMD;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Write byte capture; only whole bytes reach the buffer
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         push_reg      <= 1'b0;
         push_data_reg <= 16'h0000;
      end else begin
         push_reg <= act && fall && st_reg == msp_pkg::MSP_WR && cnt_reg[2:0] == 3'h7;
         // First byte goes to the highest lane
         push_data_reg <= {addr_reg, 2'(nb_reg - 2'h1 - cnt_reg[4:3]), rx_next};
      end
   end

   // Sticky: a full buffer means the host ignored the byte spacing
   always_ff @(posedge clk) begin
      if (srst) drop_reg <= 1'b0;
      else if (push_reg && !fifo_ready) drop_reg <= 1'b1;
   end

   msp_fifo #(.W(msp_pkg::FIFO_W), .DEPTH(DEPTH)) u_fifo (
      .clk       (clk),
      .srst      (srst),
      .in_valid  (push_reg),
      .in_ready  (fifo_ready),
      .in_data   (push_data_reg),
      .out_valid (wr_valid),
      .out_ready (wr_ready),
      .out_data  (fifo_out)
   );

   assign wr_addr = fifo_out[15:10];
   assign wr_lane = fifo_out[9:8];
   assign wr_byte = fifo_out[7:0] & msp_pkg::msp_lane_mask(fifo_out[15:10], fifo_out[9:8]);
   assign wr_drop = drop_reg;

   // ------------------------------------------------------------
   // Register array, one byte per commit
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < 64; i++) regs_reg[i] <= msp_pkg::REG_RESET;
      end else if (wr_valid && wr_ready) begin
         regs_reg[wr_addr][{wr_lane, 3'h0} +: 8] <= wr_byte;
      end else if (upd_valid) begin
         regs_reg[upd_addr] <= upd_data;
      end
   end

   // ------------------------------------------------------------
   // Read shifter and output enable
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst || cs_edge) begin
         oe_reg   <= 1'b0;
         dout_reg <= 1'b0;
      end else if (decode) begin
         case (dec_nb)
            2'h1:    tx_reg <= {rd_val[7:0], 16'h0000};
            2'h2:    tx_reg <= {rd_val[15:0], 8'h00};
            default: tx_reg <= rd_val;
         endcase
      end else if (act && st_reg == msp_pkg::MSP_RD) begin
         if (rise) begin
            dout_reg <= tx_reg[23];
            tx_reg   <= {tx_reg[22:0], 1'b0};
            oe_reg   <= 1'b1;
         end else if (fall && cnt_reg == {nb_reg, 3'h0}) begin
            oe_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) chk_reg <= msp_pkg::CHK_RESET;
      else if (decode && !cmd_next[msp_pkg::CMD_RW_POS]) chk_reg <= 6'h00;
      else if (act && st_reg == msp_pkg::MSP_RD && rise)
         chk_reg <= 6'(chk_reg + {5'h00, tx_reg[23]});
   end

   assign link.dout    = dout_reg;
   assign link.dout_oe = oe_reg;
   assign ones_count   = chk_reg;
endmodule // msp_dev

// ---- rtl/msp_pkg.sv ----
// Operation
// - Input bits sampled on serial clock fall
// - Output bits driven from serial clock rise
// - Select falling edge restarts port in command mode
// - Select rising mid-transfer aborts and floats output
// - Tied-low select: host finishes every transfer
// - After any reset, first byte is command
// - Command: top bit direction, six address bits
// - Completed transfer returns port to command mode
// - Transfer completes at register's last bit
// - Write: top bit one, data on falls
// - Bytes committed singly, one microsecond apart; after a stall the buffer releases them back to back
// - Aborted partial write byte is discarded
// - First write byte lands in top byte
// - Data right-justified, unused upper bits ignored
// - Ones count cleared before first read bit
// - Ones count adds each driven bit
// - Reading ones count recounts its own value
// - Read: top bit zero, data from rise
// - Output released on last fall or abort
// - Host waits one microsecond after write
// - Host sends zero in unused bit six
package msp_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int BYTE_GAP_NS   = 1000;
   localparam int BYTE_GAP_CYC  = (BYTE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCLK_HALF_CYC = 8;

   // ------------------------------------------------------------
   // Command byte and register map
   // ------------------------------------------------------------
   localparam int          CMD_RW_POS  = 7;
   localparam int          ADDR_W      = 6;
   localparam int          DATA_W      = 24;
   localparam int          FIFO_DEPTH  = 16;
   localparam int          FIFO_W      = 16;
   localparam logic [5:0]  CHK_ADDR    = 6'h3E;
   localparam logic [5:0]  NARROW_ADDR = 6'h01;
   localparam logic [4:0]  CHK_BITS    = 5'h06;
   localparam logic [4:0]  NARROW_BITS = 5'h0C;
   localparam logic [4:0]  FULL_BITS   = 5'h18;
   localparam logic [23:0] REG_RESET   = 24'h000000;
   localparam logic [5:0]  CHK_RESET   = 6'h00;

   typedef enum logic [1:0] {MSP_CMD, MSP_WR, MSP_RD} msp_dev_st_t;
   typedef enum logic [1:0] {MSP_IDLE, MSP_SHIFT, MSP_TAIL, MSP_GAP} msp_host_st_t;

   function automatic logic [4:0] msp_reg_bits(input logic [5:0] a);
      case (a)
         CHK_ADDR:    return CHK_BITS;
         NARROW_ADDR: return NARROW_BITS;
         default:     return FULL_BITS;
      endcase
   endfunction

   function automatic logic [1:0] msp_reg_bytes(input logic [5:0] a);
      logic [5:0] b;
      b = {1'b0, msp_reg_bits(a)} + 6'h07;
      return b[4:3];
   endfunction

   // Upper unused bits of the top lane are dropped on commit
   function automatic logic [7:0] msp_lane_mask(input logic [5:0] a, input logic [1:0] lane);
      logic [4:0] nbits;
      logic [2:0] rem;
      logic [8:0] m;
      nbits = msp_reg_bits(a);
      rem   = nbits[2:0];
      m     = (9'h001 << rem) - 9'h001;
      if (lane == msp_reg_bytes(a) - 2'h1 && rem != 3'h0) return m[7:0];
      return 8'hFF;
   endfunction
endpackage

// ---- rtl/msp_if.sv ----
`timescale 1ns/1ps
interface msp_if;
   logic sclk;
   logic cs_n;
   logic din;
   logic dout;
   logic dout_oe;

   modport dev  (input sclk, input cs_n, input din, output dout, output dout_oe);
   modport host (output sclk, output cs_n, output din, input dout, input dout_oe);
endinterface

// ---- rtl/msp_host.sv ----
`timescale 1ns/1ps
// ------------------------------------------------------------
// Host end: makes the serial clock by dividing clk
// ------------------------------------------------------------
module msp_host #(
   parameter int SCLK_HALF = msp_pkg::SCLK_HALF_CYC
) (
   input  wire logic        clk,
   input  wire logic        srst,
   msp_if.host              link,
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic        cmd_write,
   input  wire logic [5:0]  cmd_addr,
   input  wire logic [23:0] cmd_wdata,
   output logic             rsp_valid,
   output logic [23:0]      rsp_data
);
   msp_pkg::msp_host_st_t st_reg;
   logic [7:0]            div_reg;
   logic [5:0]            left_reg;
   logic [31:0]           tx_reg;
   logic [23:0]           rx_reg;
   logic [1:0]            sync1_reg;
   logic [1:0]            sync2_reg;
   logic                  sclk_reg;
   logic                  cs_n_reg;
   logic                  din_reg;
   logic                  wr_reg;
   logic                  rsp_valid_reg;
   logic [23:0]           rsp_data_reg;
   logic [1:0]            req_nb;
   logic [23:0]           req_data;
   logic                  accept;
   logic                  half_done;
   logic                  fall_now;
   logic                  rise_now;
   logic                  last_fall;
   logic                  tail_rise;
   logic                  tail_end;
   logic                  gap_end;
   logic                  rx_bit;

   // ------------------------------------------------------------
   // Request decode
   // ------------------------------------------------------------
   assign cmd_ready = st_reg == msp_pkg::MSP_IDLE;
   assign accept    = cmd_valid && cmd_ready;
   assign req_nb    = msp_pkg::msp_reg_bytes(cmd_addr);

   // Data is right-justified in whole bytes, top byte sent first
   always_comb begin
      case (req_nb)
         2'h1:    req_data = {cmd_wdata[7:0], 16'h0000};
         2'h2:    req_data = {cmd_wdata[15:0], 8'h00};
         default: req_data = cmd_wdata;
      endcase
   end

   // ------------------------------------------------------------
   // Serial clock divider and frame sequencing
   // ------------------------------------------------------------
   assign half_done = (st_reg == msp_pkg::MSP_SHIFT || st_reg == msp_pkg::MSP_TAIL)
                      && div_reg == 8'(SCLK_HALF - 1);
   assign fall_now  = half_done && st_reg == msp_pkg::MSP_SHIFT && sclk_reg;
   assign rise_now  = half_done && st_reg == msp_pkg::MSP_SHIFT && !sclk_reg;
   assign last_fall = fall_now && left_reg == 6'h01;
   assign tail_rise = half_done && st_reg == msp_pkg::MSP_TAIL && !sclk_reg;
   assign tail_end  = half_done && st_reg == msp_pkg::MSP_TAIL && sclk_reg;
   assign gap_end   = st_reg == msp_pkg::MSP_GAP && div_reg == 8'(msp_pkg::BYTE_GAP_CYC - 1);

   always_ff @(posedge clk) begin
      if (srst || accept || half_done || gap_end) div_reg <= 8'h00;
      else div_reg <= 8'(div_reg + 8'h01);
   end

   // A byte lasts sixteen half periods, well beyond the commit spacing
   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg <= msp_pkg::MSP_IDLE;
      end else begin
         case (st_reg)
            msp_pkg::MSP_IDLE:  if (accept) st_reg <= msp_pkg::MSP_SHIFT;
            msp_pkg::MSP_SHIFT: if (last_fall) st_reg <= msp_pkg::MSP_TAIL;
            msp_pkg::MSP_TAIL:  if (tail_end) st_reg <= msp_pkg::MSP_GAP;
            msp_pkg::MSP_GAP:   if (gap_end) st_reg <= msp_pkg::MSP_IDLE;
            default:            st_reg <= msp_pkg::MSP_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Link pins; the clock idles high and only moves while selected
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         cs_n_reg <= 1'b1;
         sclk_reg <= 1'b1;
      end else begin
         if (accept) cs_n_reg <= 1'b0;
         else if (tail_end) cs_n_reg <= 1'b1;
         if (fall_now) sclk_reg <= 1'b0;
         else if (rise_now || tail_rise) sclk_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         din_reg  <= 1'b0;
         tx_reg   <= 32'h00000000;
         left_reg <= 6'h00;
         wr_reg   <= 1'b0;
      end else if (accept) begin
         din_reg  <= cmd_write;
         tx_reg   <= {1'b0, cmd_addr, req_data, 1'b0};
         left_reg <= {1'b0, req_nb, 3'h0} + 6'h08;
         wr_reg   <= cmd_write;
      end else begin
         if (rise_now) begin
            din_reg <= tx_reg[31];
            tx_reg  <= {tx_reg[30:0], 1'b0};
         end
         if (fall_now) left_reg <= left_reg - 6'h01;
      end
   end

   // ------------------------------------------------------------
   // Read data capture
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         sync1_reg <= 2'h0;
         sync2_reg <= 2'h0;
      end else begin
         sync1_reg <= {link.dout_oe, link.dout};
         sync2_reg <= sync1_reg;
      end
   end

   // A released line reads as zero, so command-phase bits fill with zeros
   assign rx_bit = sync2_reg[1] && sync2_reg[0];

   always_ff @(posedge clk) begin
      if (srst || accept) rx_reg <= 24'h000000;
      else if (fall_now) rx_reg <= {rx_reg[22:0], rx_bit};
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rsp_valid_reg <= 1'b0;
         rsp_data_reg  <= 24'h000000;
      end else begin
         rsp_valid_reg <= tail_end && !wr_reg;
         if (tail_end && !wr_reg) rsp_data_reg <= rx_reg;
      end
   end

   assign link.sclk = sclk_reg;
   assign link.cs_n = cs_n_reg;
   assign link.din  = din_reg;
   assign rsp_valid = rsp_valid_reg;
   assign rsp_data  = rsp_data_reg;
endmodule // msp_host

// ---- test/msp_link_sva.sv ----
`timescale 1ns/1ps
module msp_link_sva (
   input wire logic clk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic dout,
   input wire logic dout_oe
);
   logic       sclk_q;
   logic [3:0] fall_cnt;
   logic       wr_frame;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // ------------------------------------------------------------
   // Frame tracking
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      sclk_q <= sclk;
   end

   // Saturates so long reads cannot wrap back to a command position
   always_ff @(posedge clk) begin
      if (srst || cs_n) begin
         fall_cnt <= 4'h0;
      end else if (sclk_q && !sclk && fall_cnt != 4'hF) begin
         fall_cnt <= fall_cnt + 4'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || cs_n) begin
         wr_frame <= 1'h0;
      end else if (sclk_q && !sclk && fall_cnt == 4'h0) begin
         wr_frame <= din;
      end
   end

   // ------------------------------------------------------------
   // Sequences
   // ------------------------------------------------------------
   sequence bit_six_s;
      $fell(sclk) && !cs_n && fall_cnt == 4'h1;
   endsequence

   sequence read_cmd_done_s;
      $rose(sclk) && !cs_n && fall_cnt == 4'h8 && !wr_frame;
   endsequence

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sclk_frame_a: assert property ($changed(sclk) |-> !cs_n)
      else $error("serial clock moved while deselected");
   float_deselect_a: assert property (cs_n [*4] |-> !dout_oe)
      else $error("serial output driven while deselected");
   quiet_select_a: assert property ($fell(cs_n) |-> !dout_oe [*8])
      else $error("serial output driven during command byte");
   din_stable_a: assert property ($fell(sclk) && !cs_n |-> $stable(din))
      else $error("input bit moved at sampling edge");
   dout_high_a: assert property (dout_oe && $past(dout_oe) && $changed(dout) |-> sclk)
      else $error("output bit changed outside high clock phase");
   oe_start_a: assert property (read_cmd_done_s |-> ##[1:6] dout_oe)
      else $error("read data not driven after command");
   oe_end_a: assert property ($fell(dout_oe) && !cs_n |-> !sclk)
      else $error("output released outside low clock phase");
   bit_six_a: assert property (bit_six_s |-> !din)
      else $error("unused command bit sent as one");
   write_quiet_a: assert property (wr_frame |-> !dout_oe)
      else $error("output driven during a write");
endmodule // msp_link_sva

// ---- test/msp_tb.sv ----
`timescale 1ns/1ps
module msp_tb;
   logic        clk;
   logic        srst;
   logic        wr_valid;
   logic        wr_ready;
   logic [5:0]  wr_addr;
   logic [1:0]  wr_lane;
   logic [7:0]  wr_byte;
   logic        wr_drop;
   logic        upd_valid;
   logic [5:0]  upd_addr;
   logic [23:0] upd_data;
   logic [5:0]  ones_count;
   logic        cmd_valid;
   logic        cmd_ready;
   logic        cmd_write;
   logic [5:0]  cmd_addr;
   logic [23:0] cmd_wdata;
   logic        rsp_valid;
   logic [23:0] rsp_data;
   logic [15:0] wq[$];
   int          mismatches;
   int          check_count;

   msp_if msp_if_i ();
   msp_dev msp_dev_i (.clk(clk), .srst(srst), .link(msp_if_i.dev), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_lane(wr_lane), .wr_byte(wr_byte),
      .wr_drop(wr_drop), .upd_valid(upd_valid), .upd_addr(upd_addr), .upd_data(upd_data),
      .ones_count(ones_count));
   msp_host msp_host_i (.clk(clk), .srst(srst), .link(msp_if_i.host), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
   msp_link_sva msp_link_sva_i (.clk(clk), .srst(srst), .sclk(msp_if_i.sclk),
      .cs_n(msp_if_i.cs_n), .din(msp_if_i.din), .dout(msp_if_i.dout),
      .dout_oe(msp_if_i.dout_oe));

   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end

   // Committed bytes are queued so stalls can be released in one go
   always @(posedge clk) begin
      if (wr_valid === 1'h1 && wr_ready === 1'h1) wq.push_back({wr_addr, wr_lane, wr_byte});
   end

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task check(input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task conclude;
      if (mismatches == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task run_cmd(input logic w, input logic [5:0] a, input logic [23:0] d);
      cmd_valid <= 1'h1;
      cmd_write <= w;
      cmd_addr  <= a;
      cmd_wdata <= d;
      do @(posedge clk); while (cmd_ready !== 1'h1);
      cmd_valid <= 1'h0;
      @(posedge clk);
   endtask

   task wait_q(input int n);
      do @(posedge clk); while (wq.size() < n);
   endtask

   task exp_wr(input logic [5:0] a, input logic [1:0] l, input logic [7:0] b);
      check({8'h00, wq.pop_front()}, {8'h00, a, l, b});
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_write_full;
      run_cmd(1'h1, 6'h05, 24'hA5C33C);
      wait_q(3);
      exp_wr(6'h05, 2'h2, 8'hA5);
      exp_wr(6'h05, 2'h1, 8'hC3);
      exp_wr(6'h05, 2'h0, 8'h3C);
   endtask

   task t_write_narrow;
      run_cmd(1'h1, msp_pkg::NARROW_ADDR, 24'h00FABC);
      wait_q(2);
      exp_wr(msp_pkg::NARROW_ADDR, 2'h1, 8'h0A);
      exp_wr(msp_pkg::NARROW_ADDR, 2'h0, 8'hBC);
   endtask

   // Far side stalls across two writes; nothing may leak out early
   task t_stall;
      logic [47:0] d;
      d = 48'h12345689ABCD;
      wr_ready <= 1'h0;
      run_cmd(1'h1, 6'h10, d[47:24]);
      run_cmd(1'h1, 6'h11, d[23:0]);
      repeat (1400) @(posedge clk);
      check({23'h000000, wr_valid}, 24'h000001);
      check(24'(wq.size()), 24'h000000);
      check({23'h000000, wr_drop}, 24'h000000);
      wr_ready <= 1'h1;
      wait_q(6);
      for (int i = 0; i < 6; i++) begin
         exp_wr((i < 3) ? 6'h10 : 6'h11, 2'(2 - i % 3), d[47 - 8 * i -: 8]);
      end
   endtask

   task t_read(input logic [5:0] a, input logic [23:0] v);
      upd_valid <= 1'h1;
      upd_addr  <= a;
      upd_data  <= v;
      @(posedge clk);
      upd_valid <= 1'h0;
      run_cmd(1'h0, a, 24'h000000);
      do @(posedge clk); while (rsp_valid !== 1'h1);
      check(rsp_data, v);
      repeat (2) @(posedge clk);
      check({18'h00000, ones_count}, 24'($countones(v)));
   endtask

   task t_read_sum(input logic [5:0] prev);
      run_cmd(1'h0, msp_pkg::CHK_ADDR, 24'h000000);
      do @(posedge clk); while (rsp_valid !== 1'h1);
      check({18'h00000, rsp_data[5:0]}, {18'h00000, prev});
      repeat (2) @(posedge clk);
      check({18'h00000, ones_count}, 24'($countones(prev)));
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      srst        = 1'h1;
      wr_ready    = 1'h1;
      upd_valid   = 1'h0;
      upd_addr    = 6'h00;
      upd_data    = 24'h000000;
      cmd_valid   = 1'h0;
      cmd_write   = 1'h0;
      cmd_addr    = 6'h00;
      cmd_wdata   = 24'h000000;
      mismatches  = 0;
      check_count = 0;
      repeat (10) @(posedge clk);
      srst <= 1'h0;
      repeat (4) @(posedge clk);
      t_write_full;
      t_write_narrow;
      t_stall;
      t_read(6'h07, 24'hF00F81);
      t_read_sum(6'h0A);
      t_read(6'h08, 24'h800000);
      conclude;
   end

   // All scenarios need well under a third of this span
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude;
   end
endmodule // msp_tb
